// ===== cmc_mode_control.sv
// can mode control: sleep/init handshakes, config protection, test modes
`timescale 1ns/100ps
`default_nettype none
module cmc_mode_control
	import cmc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	// classic wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [5:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// system and protocol engine
	input wire logic special_mode_i,
	input wire logic cpu_stop_i,
	input wire logic cpu_wait_i,
	input wire logic rx_pin_i,
	input wire logic engine_tx_i,
	input wire logic engine_rx_busy_i,
	input wire logic tx_buffers_empty_i,
	input wire logic bus_off_i,
	input wire logic bit_tick_i,
	input wire logic [8:0] tx_err_count_i,
	input wire logic [7:0] rx_err_count_i,
	output logic tx_pin_o,
	output logic engine_rx_o,
	output logic engine_run_o,
	output logic engine_synced_o,
	output logic ack_suppress_o,
	output logic err_freeze_o,
	output logic loop_irq_both_o,
	output logic clock_source_o,
	output logic wake_o
);
	logic [7:0] ctl0_reg, ctl1_reg, btra_reg, btrb_reg, idac_reg;
	logic [7:0] rflg_reg, rier_reg, tflg_reg, tier_reg;
	logic [7:0] tarq_reg, taak_reg, tbsl_reg, idsel_reg;
	logic [7:0] code_reg [8];
	logic [7:0] mask_reg [8];
	logic enable_written_reg;
	cmc_mode_t mode_reg;
	logic rx_meta_reg, rx_sync_reg, rx_prev_reg;
	logic [3:0] idle_cnt_reg;
	logic [7:0] seq_cnt_reg;
	logic [15:0] wup_cnt_reg;
	cmc_req_t req;
	logic wr, cfg_ok, in_init, in_sleep, wake_event, tx_kill, bus_rx;

	assign req = '{idx: adr_i[5:2], we: we_i, data: dat_i[7:0]};
	assign wr = cyc_i && stb_i && req.we && !ack_o && sel_i[0];
	assign in_init = ctl0_reg[CMC_C0_INIT_REQUEST] && ctl1_reg[CMC_C1_INIT_ACK];
	assign in_sleep = ctl0_reg[CMC_C0_SLEEP_REQUEST] && ctl1_reg[CMC_C1_SLEEP_ACK];
	assign cfg_ok = in_init;
	// loopback ignores the pin and listens to the transmitter
	assign bus_rx = ctl1_reg[CMC_C1_LOOP] ? engine_tx_i : rx_sync_reg;

	// receive pin synchroniser
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
			rx_prev_reg <= 1'b1;
		end else begin
			rx_meta_reg <= rx_pin_i;
			rx_sync_reg <= rx_meta_reg;
			rx_prev_reg <= rx_sync_reg;
		end
	end

	// wake filter: pulse length counted on the synchronised pin
	always_ff @(posedge clk_i) begin
		if (rst_i || rx_sync_reg) begin
			wup_cnt_reg <= '0;
		end else if (wup_cnt_reg != 16'(CMC_TWUP_CYC)) begin
			wup_cnt_reg <= wup_cnt_reg + 16'h0001;
		end
	end
	always_comb begin
		if (ctl1_reg[CMC_C1_WFSEL]) begin
			wake_event = (wup_cnt_reg == 16'(CMC_TWUP_CYC));
		end else begin
			wake_event = rx_prev_reg && !rx_sync_reg;
		end
		wake_event = wake_event && ctl0_reg[CMC_C0_WAKE] && in_sleep;
	end

	// mode sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_reg <= CMC_INIT;
		end else begin
			unique case (mode_reg)
				CMC_RUN: begin
					if (ctl0_reg[CMC_C0_INIT_REQUEST]) begin
						mode_reg <= CMC_INIT;
					end else if (ctl0_reg[CMC_C0_SLEEP_REQUEST] && !engine_rx_busy_i &&
						tx_buffers_empty_i) begin
						mode_reg <= CMC_SLEEP;
					end
				end
				CMC_SLEEP: begin
					if (ctl0_reg[CMC_C0_INIT_REQUEST]) begin
						mode_reg <= CMC_INIT;
					end else if (!ctl0_reg[CMC_C0_SLEEP_REQUEST]) begin
						mode_reg <= CMC_RESYNC;
					end
				end
				CMC_INIT: begin
					if (!ctl0_reg[CMC_C0_INIT_REQUEST]) begin
						mode_reg <= CMC_RESYNC;
					end
				end
				CMC_RESYNC: begin
					if (ctl0_reg[CMC_C0_INIT_REQUEST]) begin
						mode_reg <= CMC_INIT;
					end else if (idle_cnt_reg == 4'(CMC_IDLE_BITS) &&
						(!bus_off_i || seq_cnt_reg == 8'(CMC_BUSOFF_SEQS))) begin
						mode_reg <= CMC_RUN;
					end
				end
			endcase
		end
	end

	// recessive-bit run counters used for resync
	always_ff @(posedge clk_i) begin
		if (rst_i || mode_reg != CMC_RESYNC) begin
			idle_cnt_reg <= '0;
			seq_cnt_reg <= '0;
		end else if (bit_tick_i) begin
			if (!bus_rx) begin
				idle_cnt_reg <= '0;
			end else if (idle_cnt_reg == 4'(CMC_IDLE_BITS)) begin
				// bus off: this bit opens the next run; the finished run
				// was counted when it reached its length, not here again
				if (bus_off_i) begin
					idle_cnt_reg <= 4'h1;
				end
			end else begin
				idle_cnt_reg <= idle_cnt_reg + 4'h1;
				if (idle_cnt_reg == 4'(CMC_IDLE_BITS - 1) && bus_off_i) begin
					seq_cnt_reg <= seq_cnt_reg + 8'h01;
				end
			end
		end
	end

	// control zero: requests and wake enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl0_reg <= CMC_RST_CTL0;
		end else begin
			if (wr && req.idx == CMC_IDX_CTL0) begin
				ctl0_reg <= req.data & ~CMC_C0_KEEP & ~8'h50;
				ctl0_reg[CMC_C0_WAKE] <= req.data[CMC_C0_WAKE];
				// requests can only be dropped once the mode was reached
				ctl0_reg[CMC_C0_SLEEP_REQUEST] <= req.data[CMC_C0_SLEEP_REQUEST] ||
					(ctl0_reg[CMC_C0_SLEEP_REQUEST] && !in_sleep);
				ctl0_reg[CMC_C0_INIT_REQUEST] <= req.data[CMC_C0_INIT_REQUEST] ||
					(ctl0_reg[CMC_C0_INIT_REQUEST] && !in_init);
				if (ctl0_reg[CMC_C0_INIT_REQUEST]) begin
					ctl0_reg[7:3] <= CMC_RST_CTL0[7:3];
				end
			end else if (ctl0_reg[CMC_C0_INIT_REQUEST] && !in_init) begin
				ctl0_reg <= (ctl0_reg & CMC_C0_KEEP) |
					(CMC_RST_CTL0 & ~CMC_C0_KEEP);
			end
			// wake clears the request itself; it wins over a cpu write
			if (wake_event) begin
				ctl0_reg[CMC_C0_SLEEP_REQUEST] <= 1'b0;
			end
		end
	end

	// control one: handshake flags and protected configuration
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl1_reg <= CMC_RST_CTL1;
			enable_written_reg <= 1'b0;
		end else begin
			if (wr && req.idx == CMC_IDX_CTL1 && cfg_ok) begin
				ctl1_reg <= (ctl1_reg & ~CMC_C1_WMASK) |
					(req.data & CMC_C1_WMASK);
				if (special_mode_i || !enable_written_reg) begin
					ctl1_reg[CMC_C1_ENABLE] <= req.data[CMC_C1_ENABLE];
					enable_written_reg <= 1'b1;
				end
			end
			ctl1_reg[CMC_C1_INIT_ACK] <= (mode_reg == CMC_INIT) &&
				ctl0_reg[CMC_C0_INIT_REQUEST];
			ctl1_reg[CMC_C1_SLEEP_ACK] <= (mode_reg == CMC_SLEEP) &&
				ctl0_reg[CMC_C0_SLEEP_REQUEST] && !wake_event;
		end
	end

	// remaining registers: protected config and init-reset group
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			btra_reg <= CMC_RST_ZERO;
			btrb_reg <= CMC_RST_ZERO;
			idac_reg <= CMC_RST_ZERO;
			idsel_reg <= CMC_RST_ZERO;
			rflg_reg <= CMC_RST_ZERO;
			rier_reg <= CMC_RST_ZERO;
			tflg_reg <= CMC_RST_TFLG;
			tier_reg <= CMC_RST_ZERO;
			tarq_reg <= CMC_RST_ZERO;
			taak_reg <= CMC_RST_ZERO;
			tbsl_reg <= CMC_RST_ZERO;
		end else if (ctl0_reg[CMC_C0_INIT_REQUEST] && !in_init) begin
			rflg_reg <= rflg_reg & CMC_RFLG_KEEP;
			rier_reg <= rier_reg & CMC_RIER_KEEP;
			tflg_reg <= CMC_RST_TFLG;
			tier_reg <= CMC_RST_ZERO;
			tarq_reg <= CMC_RST_ZERO;
			taak_reg <= CMC_RST_ZERO;
			tbsl_reg <= CMC_RST_ZERO;
		end else if (wr) begin
			// protected registers drop writes outside init
			if (cfg_ok && req.idx == CMC_IDX_BTRA) btra_reg <= req.data;
			if (cfg_ok && req.idx == CMC_IDX_BTRB) btrb_reg <= req.data;
			if (cfg_ok && req.idx == CMC_IDX_IDAC) idac_reg <= req.data;
			if (cfg_ok && req.idx == CMC_IDX_SEL) idsel_reg <= req.data;
			if (req.idx == CMC_IDX_RFLG) rflg_reg <= rflg_reg & ~req.data;
			if (req.idx == CMC_IDX_RIER) rier_reg <= req.data;
			if (req.idx == CMC_IDX_TFLG) tflg_reg <= tflg_reg | req.data;
			if (req.idx == CMC_IDX_TIER) tier_reg <= req.data;
			if (req.idx == CMC_IDX_TARQ) tarq_reg <= req.data;
			if (req.idx == CMC_IDX_TBSL) tbsl_reg <= req.data;
		end
	end

	// acceptance code and mask banks, reached through the select register
	for (genvar g = 0; g < 8; g++) begin : g_accept
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				code_reg[g] <= CMC_RST_ZERO;
				mask_reg[g] <= CMC_RST_ZERO;
			end else if (wr && cfg_ok && req.idx == CMC_IDX_IDRG &&
				idsel_reg[2:0] == 3'(g)) begin
				if (idsel_reg[3]) begin
					mask_reg[g] <= req.data;
				end else begin
					code_reg[g] <= req.data;
				end
			end
		end
	end

	// pin and engine controls, all registered
	assign tx_kill = ctl0_reg[CMC_C0_INIT_REQUEST] || cpu_stop_i ||
		(cpu_wait_i && ctl0_reg[5]) || ctl1_reg[CMC_C1_LOOP] ||
		ctl1_reg[CMC_C1_LISTEN];
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_pin_o <= 1'b1;
			engine_rx_o <= 1'b1;
			engine_run_o <= 1'b0;
			engine_synced_o <= 1'b0;
			ack_suppress_o <= 1'b0;
			err_freeze_o <= 1'b0;
			loop_irq_both_o <= 1'b0;
			clock_source_o <= 1'b0;
			wake_o <= 1'b0;
		end else begin
			// recessive forced while init is asked for, in stop, in listen
			tx_pin_o <= tx_kill ? 1'b1 : engine_tx_i;
			engine_rx_o <= bus_rx;
			engine_run_o <= ctl1_reg[CMC_C1_ENABLE] && mode_reg == CMC_RUN &&
				!ctl0_reg[CMC_C0_INIT_REQUEST];
			engine_synced_o <= mode_reg == CMC_RUN && !ctl0_reg[CMC_C0_INIT_REQUEST];
			ack_suppress_o <= ctl1_reg[CMC_C1_LISTEN] || ctl1_reg[CMC_C1_LOOP];
			err_freeze_o <= ctl1_reg[CMC_C1_LISTEN] || in_init;
			loop_irq_both_o <= ctl1_reg[CMC_C1_LOOP];
			clock_source_o <= ctl1_reg[CMC_C1_CLOCK_SOURCE_SELECT];
			wake_o <= wake_event;
		end
	end

	// wishbone read data and one-cycle acknowledge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= CMC_ERR_DATA;
		end else begin
			ack_o <= cyc_i && stb_i && !ack_o;
			dat_o <= CMC_ERR_DATA;
			unique case (req.idx)
				CMC_IDX_CTL0: dat_o[7:0] <= ctl0_reg |
					{1'b0, engine_rx_busy_i, 1'b0, engine_synced_o, 4'h0};
				CMC_IDX_CTL1: dat_o[7:0] <= ctl1_reg;
				CMC_IDX_BTRA: dat_o[7:0] <= btra_reg;
				CMC_IDX_BTRB: dat_o[7:0] <= btrb_reg;
				CMC_IDX_IDAC: dat_o[7:0] <= idac_reg;
				CMC_IDX_RFLG: dat_o[7:0] <= rflg_reg;
				CMC_IDX_RIER: dat_o[7:0] <= rier_reg;
				CMC_IDX_TFLG: dat_o[7:0] <= tflg_reg;
				CMC_IDX_TIER: dat_o[7:0] <= tier_reg;
				CMC_IDX_TARQ: dat_o[7:0] <= tarq_reg;
				CMC_IDX_TAAK: dat_o[7:0] <= taak_reg;
				CMC_IDX_TBSL: dat_o[7:0] <= tbsl_reg;
				CMC_IDX_STAT: dat_o[16:0] <= {tx_err_count_i, rx_err_count_i};
				CMC_IDX_IDRG: dat_o[7:0] <= idsel_reg[3] ?
					mask_reg[idsel_reg[2:0]] : code_reg[idsel_reg[2:0]];
				CMC_IDX_SEL: dat_o[7:0] <= idsel_reg;
				default: dat_o <= CMC_ERR_DATA;
			endcase
		end
	end

	a_init_ack_rise: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(ctl0_reg[CMC_C0_INIT_REQUEST]) |-> ##[1:3] ctl1_reg[CMC_C1_INIT_ACK])
		else $error("init ack not raised");
	a_tx_init_rec: assert property (@(posedge clk_i) disable iff (rst_i)
		ctl0_reg[CMC_C0_INIT_REQUEST] |=> tx_pin_o)
		else $error("tx pin not recessive in init");
	a_listen_no_tx: assert property (@(posedge clk_i) disable iff (rst_i)
		ctl1_reg[CMC_C1_LISTEN] |=> tx_pin_o)
		else $error("transmit while listening");
	a_loop_tx_rec: assert property (@(posedge clk_i) disable iff (rst_i)
		ctl1_reg[CMC_C1_LOOP] |=> tx_pin_o && engine_rx_o == $past(engine_tx_i))
		else $error("loopback path wrong");
	a_sleep_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(ctl1_reg[CMC_C1_SLEEP_ACK]) |->
		$past(tx_buffers_empty_i && !engine_rx_busy_i, 2))
		else $error("sleep entered with tx pending");
	a_sleep_ack_req: assert property (@(posedge clk_i) disable iff (rst_i)
		ctl1_reg[CMC_C1_SLEEP_ACK] |-> $past(ctl0_reg[CMC_C0_SLEEP_REQUEST]))
		else $error("sleep ack without request");
	a_btra_protect: assert property (@(posedge clk_i) disable iff (rst_i)
		!cfg_ok && !ctl0_reg[CMC_C0_INIT_REQUEST] |=> $stable(btra_reg))
		else $error("protected register changed");
	a_init_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		ctl0_reg[CMC_C0_INIT_REQUEST] && !in_init |=> ctl0_reg[CMC_C0_INIT_REQUEST])
		else $error("init request dropped early");
	a_clk_src: assert property (@(posedge clk_i) disable iff (rst_i)
		##1 clock_source_o == $past(ctl1_reg[CMC_C1_CLOCK_SOURCE_SELECT]))
		else $error("clock source mismatch");
	c_sleep: cover property (@(posedge clk_i) in_sleep);
	c_wake: cover property (@(posedge clk_i) wake_event);
	c_resync: cover property (@(posedge clk_i)
		mode_reg == CMC_RESYNC ##1 mode_reg == CMC_RUN);
endmodule
`default_nettype wire

// ===== cmc_pkg.sv
// package for the can mode control block: register map, fields, timing
package cmc_pkg;
	// register word offsets (byte address = 4 * index)
	localparam logic [3:0] CMC_IDX_CTL0 = 4'h0;
	localparam logic [3:0] CMC_IDX_CTL1 = 4'h1;
	localparam logic [3:0] CMC_IDX_BTRA = 4'h2;
	localparam logic [3:0] CMC_IDX_BTRB = 4'h3;
	localparam logic [3:0] CMC_IDX_IDAC = 4'h4;
	localparam logic [3:0] CMC_IDX_RFLG = 4'h5;
	localparam logic [3:0] CMC_IDX_RIER = 4'h6;
	localparam logic [3:0] CMC_IDX_TFLG = 4'h7;
	localparam logic [3:0] CMC_IDX_TIER = 4'h8;
	localparam logic [3:0] CMC_IDX_TARQ = 4'h9;
	localparam logic [3:0] CMC_IDX_TAAK = 4'ha;
	localparam logic [3:0] CMC_IDX_TBSL = 4'hb;
	localparam logic [3:0] CMC_IDX_STAT = 4'hc;
	localparam logic [3:0] CMC_IDX_IDRG = 4'hd;
	localparam logic [3:0] CMC_IDX_SEL = 4'he;
	// control zero fields
	localparam int CMC_C0_INIT_REQUEST = 0;
	localparam int CMC_C0_SLEEP_REQUEST = 1;
	localparam int CMC_C0_WAKE = 2;
	localparam int CMC_C0_SYNC = 4;
	localparam int CMC_C0_RXACT = 6;
	localparam logic [7:0] CMC_C0_KEEP = 8'h07;
	// control one fields
	localparam int CMC_C1_INIT_ACK = 0;
	localparam int CMC_C1_SLEEP_ACK = 1;
	localparam int CMC_C1_WFSEL = 2;
	localparam int CMC_C1_LISTEN = 4;
	localparam int CMC_C1_LOOP = 5;
	localparam int CMC_C1_CLOCK_SOURCE_SELECT = 6;
	localparam int CMC_C1_ENABLE = 7;
	localparam logic [7:0] CMC_C1_WMASK = 8'h7c;
	// receive flag bits kept across init (receiver/transmitter state)
	localparam logic [7:0] CMC_RFLG_KEEP = 8'h3c;
	localparam logic [7:0] CMC_RIER_KEEP = 8'h3c;
	// reset values
	localparam logic [7:0] CMC_RST_CTL0 = 8'h01;
	localparam logic [7:0] CMC_RST_CTL1 = 8'h11;
	localparam logic [7:0] CMC_RST_TFLG = 8'h07;
	localparam logic [7:0] CMC_RST_ZERO = 8'h00;
	localparam logic [31:0] CMC_ERR_DATA = 32'h0;
	// timing
	localparam int CMC_CLK_MHZ = 200;
	localparam int CMC_IDLE_BITS = 11;
	localparam int CMC_BUSOFF_SEQS = 128;
	localparam int CMC_TWUP_NS = 2000;
	localparam int CMC_TWUP_CYC = (CMC_TWUP_NS * CMC_CLK_MHZ + 999) / 1000;
	// bus off recovery needs the 11-bit idle run this many times
	typedef enum logic [1:0] {CMC_RUN, CMC_SLEEP, CMC_INIT, CMC_RESYNC} cmc_mode_t;
	typedef struct packed {
		logic [3:0] idx;
		logic we;
		logic [7:0] data;
	} cmc_req_t;
endpackage

// ===== cmc_bus_node.sv
// behavioural model of the other nodes sharing the can bus
`timescale 1ns/100ps
`default_nettype none
module cmc_bus_node
	import cmc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tx_pin_i,
	input wire logic send_i,
	input wire logic [9:0] dom_len_i,
	output logic rx_pin_o,
	output logic bit_tick_o
);
	logic [1:0] div_reg;
	logic [9:0] dom_reg;
	// four clocks a bit keeps the 128-run bus off recovery short
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_reg <= 2'h0;
		end else begin
			div_reg <= div_reg + 2'h1;
		end
	end
	assign bit_tick_o = (div_reg == 2'h3);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dom_reg <= 10'h0;
		end else if (send_i) begin
			dom_reg <= dom_len_i;
		end else if (dom_reg != 10'h0) begin
			dom_reg <= dom_reg - 10'h1;
		end
	end
	// wired-and bus: any dominant node pulls the line low
	assign rx_pin_o = tx_pin_i & (dom_reg == 10'h0);
endmodule
`default_nettype wire

// ===== tb_cmc_mode_control.sv
// self-checking testbench for the can mode control block
`timescale 1ns/100ps
`default_nettype none
module tb_cmc_mode_control
	import cmc_pkg::*;
();
	logic clk, rst, cyc, stb, we, ack, stop, cpuwait, etx, rxbusy, busoff;
	logic send, txpin, erx, rxpin, tick, synced, acksup, frz, loopirq;
	logic clock_source_select, wake, woke, spec, txempty;
	logic [5:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q;
	logic [8:0] txerr;
	logic [7:0] rxerr;
	logic [9:0] domlen;
	int miscompares = 0;
	int tests_run = 0;
	cmc_mode_control dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
		.ack_o(ack), .special_mode_i(spec), .cpu_stop_i(stop),
		.cpu_wait_i(cpuwait), .rx_pin_i(rxpin), .engine_tx_i(etx),
		.engine_rx_busy_i(rxbusy), .tx_buffers_empty_i(txempty),
		.bus_off_i(busoff), .bit_tick_i(tick), .tx_err_count_i(txerr),
		.rx_err_count_i(rxerr), .tx_pin_o(txpin), .engine_rx_o(erx),
		.engine_run_o(), .engine_synced_o(synced), .ack_suppress_o(acksup),
		.err_freeze_o(frz), .loop_irq_both_o(loopirq),
		.clock_source_o(clock_source_select), .wake_o(wake));
	cmc_bus_node node (.clk_i(clk), .rst_i(rst), .tx_pin_i(txpin),
		.send_i(send), .dom_len_i(domlen), .rx_pin_o(rxpin),
		.bit_tick_o(tick));
	always #2.5 clk = ~clk;
	// the wake pulse lasts one cycle, so latch it for later inspection
	always @(posedge clk) begin
		if (rst === 1'b1) begin
			woke <= 1'b0;
		end else if (wake === 1'b1) begin
			woke <= 1'b1;
		end
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wb(input logic [3:0] idx, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			miscompares++;
			stop_test();
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] idx, input logic [31:0] exp,
		input string name);
		wb(idx, 1'b0, 8'h00);
		check(name, q, exp);
	endtask
	// registered outputs get three clocks to settle before a look; the
	// look itself lies off the edge so no update races with it
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask
	// the caller settles first: an input argument is copied at the call
	task automatic chk1(input string name, input logic seen_now, input logic exp);
		check(name, {31'h0, seen_now}, {31'h0, exp});
		@(posedge clk);
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge clk iff tick === 1'b1);
	endtask
	task automatic pulse(input logic [9:0] len);
		domlen <= len;
		send <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
	endtask
	task automatic enter_init();
		wb(CMC_IDX_CTL0, 1'b1, 8'h01);
		repeat (8) @(posedge clk);
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		stop_test();
	end
	initial begin
		{clk, cyc, stb, we, stop, cpuwait, rxbusy, busoff, send} = '0;
		{spec, adr, wdat, domlen} = '0;
		{rst, etx, txempty, sel} = 7'h7f;
		txerr = 9'h1a5;
		rxerr = 8'h3c;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		// init is both requested and acknowledged out of reset
		repeat (8) @(posedge clk);
		rd(CMC_IDX_CTL0, 32'h01, "ctl0 reset");
		rd(CMC_IDX_CTL1, 32'h11, "ctl1 reset");
		wb(CMC_IDX_BTRA, 1'b1, 8'h5a);
		rd(CMC_IDX_BTRA, 32'h5a, "timing a in init");
		wb(CMC_IDX_CTL1, 1'b1, 8'hc0);
		rd(CMC_IDX_CTL1, 32'hc1, "ctl1 in init");
		settle();
		chk1("clock source", clock_source_select, 1'b1);
		rd(CMC_IDX_STAT, 32'h0001a53c, "err count in init");
		wb(CMC_IDX_CTL0, 1'b1, 8'h00);
		ticks(9);
		settle();
		chk1("synced early", synced, 1'b0);
		ticks(4);
		settle();
		chk1("synced", synced, 1'b1);
		rd(CMC_IDX_CTL1, 32'hc0, "ctl1 after exit");
		rd(CMC_IDX_STAT, 32'h0001a53c, "err count after exit");
		wb(CMC_IDX_BTRA, 1'b1, 8'h33);
		rd(CMC_IDX_BTRA, 32'h5a, "timing a locked");
		wb(CMC_IDX_CTL1, 1'b1, 8'h00);
		rd(CMC_IDX_CTL1, 32'hc0, "ctl1 locked");
		// flag enables written only once init has been left
		wb(CMC_IDX_TIER, 1'b1, 8'h05);
		wb(CMC_IDX_RIER, 1'b1, 8'h3f);
		etx <= 1'b0;
		settle();
		chk1("tx pin running", txpin, 1'b0);
		wb(CMC_IDX_CTL0, 1'b1, 8'h05);
		settle();
		chk1("tx pin on init", txpin, 1'b1);
		repeat (8) @(posedge clk);
		rd(CMC_IDX_TIER, 32'h00, "tx irq en");
		rd(CMC_IDX_RIER, 32'h3c, "rx irq en");
		rd(CMC_IDX_CTL0, 32'h05, "ctl0 kept");
		wb(CMC_IDX_CTL1, 1'b1, 8'he0);
		etx <= 1'b1;
		busoff <= 1'b1;
		wb(CMC_IDX_CTL0, 1'b1, 8'h04);
		ticks(11 * 127);
		settle();
		chk1("bus off wait", synced, 1'b0);
		ticks(14);
		settle();
		chk1("bus off synced", synced, 1'b1);
		pulse(10'd40);
		settle();
		chk1("loop ignores rx", erx, 1'b1);
		etx <= 1'b0;
		settle();
		chk1("loop tx pin", txpin, 1'b1);
		settle();
		chk1("loop rx", erx, 1'b0);
		settle();
		chk1("loop irqs", loopirq, 1'b1);
		{etx, busoff} <= 2'b10;
		enter_init();
		wb(CMC_IDX_CTL1, 1'b1, 8'h90);
		wb(CMC_IDX_CTL0, 1'b1, 8'h00);
		repeat (8) @(posedge clk);
		etx <= 1'b0;
		settle();
		chk1("listen tx pin", txpin, 1'b1);
		settle();
		chk1("listen no ack", acksup, 1'b1);
		settle();
		chk1("listen freeze", frz, 1'b1);
		etx <= 1'b1;
		enter_init();
		wb(CMC_IDX_CTL1, 1'b1, 8'h80);
		wb(CMC_IDX_CTL0, 1'b1, 8'h00);
		ticks(14);
		rxbusy <= 1'b1;
		wb(CMC_IDX_CTL0, 1'b1, 8'h02);
		repeat (10) @(posedge clk);
		rd(CMC_IDX_CTL1, 32'h80, "sleep held off");
		wb(CMC_IDX_CTL0, 1'b1, 8'h00);
		wb(CMC_IDX_CTL0, 1'b0, 8'h00);
		check("early sleep clear", q & 32'h2, 32'h2);
		rxbusy <= 1'b0;
		repeat (10) @(posedge clk);
		rd(CMC_IDX_CTL1, 32'h82, "sleep ack");
		pulse(10'd40);
		repeat (60) @(posedge clk);
		rd(CMC_IDX_CTL1, 32'h82, "no wake");
		check("wake off", {31'h0, woke}, 32'h0);
		wb(CMC_IDX_CTL0, 1'b1, 8'h06);
		pulse(10'd40);
		repeat (60) @(posedge clk);
		rd(CMC_IDX_CTL1, 32'h80, "woken");
		wb(CMC_IDX_CTL0, 1'b0, 8'h00);
		check("request cleared", q & 32'h2, 32'h0);
		check("wake pulse", {31'h0, woke}, 32'h1);
		etx <= 1'b0;
		settle();
		chk1("tx before stop", txpin, 1'b0);
		stop <= 1'b1;
		settle();
		chk1("tx in stop", txpin, 1'b1);
		stop <= 1'b0;
		wb(CMC_IDX_CTL0, 1'b1, 8'h20);
		cpuwait <= 1'b1;
		settle();
		chk1("tx in wait", txpin, 1'b1);
		cpuwait <= 1'b0;
		settle();
		chk1("tx after wait", txpin, 1'b0);
		// park the controller asleep before asking for init
		etx <= 1'b1;
		wb(CMC_IDX_CTL0, 1'b1, 8'h02);
		ticks(14);
		repeat (10) @(posedge clk);
		rd(CMC_IDX_CTL1, 32'h82, "asleep before init");
		wb(CMC_IDX_CTL0, 1'b1, 8'h03);
		repeat (8) @(posedge clk);
		wb(CMC_IDX_CTL1, 1'b1, 8'h84);
		rd(CMC_IDX_CTL1, 32'h85, "wake filter set");
		wb(CMC_IDX_CTL0, 1'b1, 8'h06);
		ticks(14);
		repeat (10) @(posedge clk);
		rd(CMC_IDX_CTL1, 32'h86, "filtered sleep");
		// a short dominant pulse must not pass the wake filter
		pulse(10'd100);
		repeat (120) @(posedge clk);
		rd(CMC_IDX_CTL1, 32'h86, "short pulse filtered");
		pulse(10'd500);
		repeat (520) @(posedge clk);
		rd(CMC_IDX_CTL1, 32'h84, "long pulse wakes");
		stop_test();
	end
endmodule
`default_nettype wire
